// ### rtl/counter_fault_reporting.sv
// Fault and warning reporter of a two-channel counter and encoder module
`timescale 1ns/10ps
module counter_fault_reporting
    import fault_pkg::*;
#(
    parameter int NCH       = NUM_CH,
    parameter int BLINK_HALF = BLINK_HALF_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              clkEn,
    input  wire logic              countLossDetect,
    input  wire logic              settingsLossDetect,
    input  wire logic              configDownload,
    input  wire logic              placementMismatch,
    input  wire chEvt_t [NCH-1:0]  chEvt,
    output logic        [15:0]     errorCode,
    output logic                   majorError,
    output logic                   warningActive,
    output logic                   errorLed,
    output chWarn_t     [NCH-1:0]  chWarn
);

    // The code layout only has room for two channels
    if (NCH != NUM_CH) begin : gBadNch
        $error("counter_fault_reporting: NCH must equal 2");
    end
    if (BLINK_HALF < 1) begin : gBadBlink
        $error("counter_fault_reporting: BLINK_HALF must be at least 1");
    end

    // Lowest active code wins: majors first, then warnings by kind, channel
    function automatic logic [15:0] pickCode(
        input logic               cntLost,
        input logic               setLost,
        input logic               placeBad,
        input chWarn_t [NCH-1:0]  w
    );
        logic [15:0] code;
        logic [4:0]  bits;
        code = CODE_NONE;
        // Walk from the highest code down so the lowest ends up kept
        for (int k = WARN_KINDS - 1; k >= 0; k--) begin
            for (int c = NCH - 1; c >= 0; c--) begin
                bits = w[c];
                if (bits[k]) begin
                    code = CODE_WARN_BASE + 16'(2 * k + c);
                end
            end
        end
        if (placeBad) begin
            code = CODE_PLACEMENT;
        end
        if (setLost) begin
            code = CODE_SETTINGS_LOST;
        end
        if (cntLost) begin
            code = CODE_COUNT_LOST;
        end
        return code;
    endfunction

    // Major error, warning and indicator state
    logic              countLost_r;     // Retained count lost
    logic              countLost_nxt;
    logic              settingsLost_r;  // Retained settings lost
    logic              settingsLost_nxt;
    logic              placeBad_r;      // Setup does not match placement
    logic [15:0]       errorCode_r;     // Reported code
    logic              majorError_r;    // Any major error
    logic              warning_r;       // Any warning
    chWarn_t [NCH-1:0] warn;            // Channel flags
    logic              blink;           // Blink phase

    // Decoded conditions
    wire        anyWarn      = |warn;
    wire        anyMajor     = countLost_r | settingsLost_r | placeBad_r;
    wire [15:0] codeNxt      = pickCode(countLost_r, settingsLost_r, placeBad_r, warn);
    // Blinking is allowed only while warnings stand and nothing major is up
    wire        blinkEn      = warning_r & ~majorError_r;

    // Count loss has no software clear: only reset, i.e. power cycle, ends it
    assign countLost_nxt    = countLost_r | countLossDetect;
    // Download clears, but a new loss in that cycle keeps the flag
    assign settingsLost_nxt = (settingsLost_r & ~configDownload) | settingsLossDetect;

    // Major flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            countLost_r    <= 1'b0;
            settingsLost_r <= 1'b0;
            placeBad_r     <= 1'b0;
        end else if (clkEn) begin
            countLost_r    <= countLost_nxt;
            settingsLost_r <= settingsLost_nxt;
            placeBad_r     <= placementMismatch;
        end
    end

    // One flag block per channel
    for (genvar c = 0; c < NCH; c++) begin : gCh
        channel_warnings uWarn (
            .clk   (clk),
            .rst_n (rst_n),
            .clkEn (clkEn),
            .evt   (chEvt[c]),
            .warn  (warn[c])
        );
    end

    // Reported code and summary flags, one cycle behind the flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            errorCode_r  <= CODE_NONE;
            majorError_r <= 1'b0;
            warning_r    <= 1'b0;
        end else if (clkEn) begin
            errorCode_r  <= codeNxt;
            majorError_r <= anyMajor;
            warning_r    <= anyWarn;
        end
    end

    // Blinks only while warnings stand and nothing major is up
    blink_gen #(
        .HALF_CYC (BLINK_HALF)
    ) uBlink (
        .clk    (clk),
        .rst_n  (rst_n),
        .clkEn  (clkEn),
        .enable (blinkEn),
        .blink  (blink)
    );

    // Steady for majors, blinking for warnings; no stop output, so all runs on
    assign errorLed      = majorError_r | (warning_r & blink);
    assign errorCode     = errorCode_r;
    assign majorError    = majorError_r;
    assign warningActive = warning_r;
    assign chWarn        = warn;

    // ---------------- Assertions ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Counter of cycles a blink phase has lasted, for the period check
    localparam int PW = $clog2(BLINK_HALF + 2);
    logic [PW-1:0] phaseLen_r;
    logic          blinkPrev_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phaseLen_r  <= '0;
            blinkPrev_r <= 1'b0;
        end else if (clkEn) begin
            blinkPrev_r <= blink;
            // Restart with the generator, else a stale count spoils the first phase
            if (!blinkEn) begin
                phaseLen_r <= '0;
            end else if (blink != blinkPrev_r) begin
                phaseLen_r <= PW'(1);
            end else begin
                phaseLen_r <= phaseLen_r + 1'b1;
            end
        end
    end

    // A channel clear request with no fresh overflow or zero-crossing event in the same cycle
    sequence sClearCh0;
        clkEn && (chEvt[0].counterClear || chEvt[0].runInstr)
            && !chEvt[0].overflow && !chEvt[0].zeroCross;
    endsequence

    sequence sClearedCh0;
        !warn[0].overflow && !warn[0].zeroCross;
    endsequence

    AST_COUNT_LOSS_CODE: assert property (
        clkEn && countLossDetect ##1 clkEn |=> errorCode == CODE_COUNT_LOST && majorError && errorLed
    ) else $error("count loss did not give major code");

    AST_COUNT_LOSS_STICKY: assert property (
        countLost_r |=> countLost_r
    ) else $error("count loss flag cleared without power cycle");

    AST_SETTINGS_CLEAR: assert property (
        clkEn && configDownload && !settingsLossDetect |=> !settingsLost_r
    ) else $error("config download did not clear settings loss");

    AST_SETTINGS_SET_WINS: assert property (
        clkEn && settingsLossDetect |=> settingsLost_r
    ) else $error("settings loss event was lost");

    AST_PLACEMENT_CODE: assert property (
        clkEn && placementMismatch && !countLost_r && !settingsLost_r
            && !countLossDetect && !settingsLossDetect ##1 clkEn
            |=> errorCode == CODE_PLACEMENT
    ) else $error("placement mismatch did not give its code");

    AST_LED_STEADY: assert property (
        majorError |-> errorLed
    ) else $error("indicator not steady during major error");

    AST_LED_DARK: assert property (
        !majorError && !warningActive |-> !errorLed
    ) else $error("indicator lit with nothing to report");

    AST_BLINK_HALF: assert property (
        clkEn && blink != blinkPrev_r && blinkPrev_r == $past(blink) && warning_r
            && !majorError_r && $past(blinkEn) && $past(clkEn)
            |-> phaseLen_r == PW'(BLINK_HALF)
    ) else $error("blink phase differs from half period");

    AST_OVERFLOW_SET: assert property (
        clkEn && chEvt[1].overflow |=> warn[1].overflow
    ) else $error("overflow event lost on second channel");

    AST_LIMIT_WRAP: assert property (
        clkEn && chEvt[0].limitWrap && !chEvt[0].limitHit |=> !warn[0].limit
    ) else $error("limit warning survived a wrap");

    AST_JUMP_FOLLOWS: assert property (
        clkEn && chEvt[0].ssiSample |=> warn[0].ssiJump == $past(chEvt[0].ssiJumpBad)
    ) else $error("jump warning does not follow last reading");

    AST_SSI_COMM: assert property (
        clkEn && chEvt[1].ssiCommFault |=> warn[1].ssiComm ##1 clkEn |=> warningActive
    ) else $error("link fault not reported");

    AST_ZERO_CROSS: assert property (
        clkEn && chEvt[0].zeroCross |=> warn[0].zeroCross
    ) else $error("zero crossing not flagged");

    AST_CLEAR_CH0: assert property (
        sClearCh0 |=> sClearedCh0
    ) else $error("counter clear left overflow or zero flag");

    // Same clear behaviour on the second channel
    sequence sClearCh1;
        clkEn && (chEvt[1].counterClear || chEvt[1].runInstr)
            && !chEvt[1].overflow && !chEvt[1].zeroCross;
    endsequence

    sequence sClearedCh1;
        !warn[1].overflow && !warn[1].zeroCross;
    endsequence

    AST_CLEAR_CH1: assert property (
        sClearCh1 |=> sClearedCh1
    ) else $error("counter clear left flag on second channel");

    // Count loss outranks every other code once its flag stands
    AST_COUNT_LOSS_FIRST: assert property (
        clkEn && countLost_r |=> errorCode == CODE_COUNT_LOST
    ) else $error("count loss not reported first");

    // Settings loss outranks placement and all warnings
    AST_SETTINGS_OVER_REST: assert property (
        clkEn && settingsLost_r && !countLost_r |=> errorCode == CODE_SETTINGS_LOST
    ) else $error("settings loss not reported before lower codes");

    // First channel overflow is the lowest warning code
    AST_OVERFLOW_CODE: assert property (
        clkEn && warn[0].overflow && !anyMajor |=> errorCode == CODE_OVERFLOW
    ) else $error("overflow code missing on first channel");

    AST_LIMIT_SET: assert property (
        clkEn && chEvt[1].limitHit |=> warn[1].limit
    ) else $error("limit event lost on second channel");

    // Between readings the jump flag must not move
    AST_JUMP_HOLDS: assert property (
        clkEn && !chEvt[1].ssiSample |=> warn[1].ssiJump == $past(warn[1].ssiJump)
    ) else $error("jump flag changed without a reading");

    AST_ZERO_CROSS_CH1: assert property (
        clkEn && chEvt[1].zeroCross |=> warn[1].zeroCross
    ) else $error("zero crossing lost on second channel");

    // Summary flag follows the channel flags one cycle later
    AST_WARN_ACTIVE: assert property (
        clkEn |=> warningActive == $past(anyWarn)
    ) else $error("warning summary does not follow flags");

endmodule

// ### rtl/fault_pkg.sv
// Shared constants and carrier types for the counter fault reporter
package fault_pkg;

    // No-error code, then major error codes, which are reported with a steady indicator
    localparam logic [15:0] CODE_NONE          = 16'h0000;
    localparam logic [15:0] CODE_COUNT_LOST    = 16'h1605;
    localparam logic [15:0] CODE_SETTINGS_LOST = 16'h1606;
    localparam logic [15:0] CODE_PLACEMENT     = 16'h1607;

    // Warning codes: base + 2 * kind + channel index
    localparam logic [15:0] CODE_WARN_BASE     = 16'h1800;
    localparam logic [15:0] CODE_OVERFLOW      = 16'h1800;
    localparam logic [15:0] CODE_LIMIT         = 16'h1802;
    localparam logic [15:0] CODE_SSI_JUMP      = 16'h1804;
    localparam logic [15:0] CODE_SSI_COMM      = 16'h1806;
    localparam logic [15:0] CODE_ZERO_CROSS    = 16'h1808;
    localparam int          WARN_KINDS         = 5;
    localparam int          NUM_CH             = 2;

    // Blink timing: full period in seconds, clock in hertz
    localparam real         BLINK_PERIOD_S     = 0.5;
    localparam real         CLK_FREQ_HZ        = 250.0e6;
    // Half period in cycles, rounded down, never below one
    localparam int          BLINK_HALF_RAW     = int'($floor(BLINK_PERIOD_S * CLK_FREQ_HZ / 2.0));
    localparam int          BLINK_HALF_CYC     = (BLINK_HALF_RAW < 1) ? 1 : BLINK_HALF_RAW;

    // Per-channel events from the counting and encoder logic, one-cycle pulses
    typedef struct packed {
        logic overflow;      // Counter wrapped past its range
        logic limitHit;      // Linear count passed upper or lower limit
        logic limitWrap;     // Count went from maximum back to minimum
        logic ssiSample;     // A new encoder reading was taken
        logic ssiJumpBad;    // That reading moved more than allowed
        logic ssiCommFault;  // Link fault or failed parity
        logic zeroCross;     // Absolute position crossed zero
        logic counterClear;  // Clear, reset or preset of the counter
        logic runInstr;      // Counter start instruction executed again
    } chEvt_t;

    // Per-channel warning flags; bit order equals code order within a channel
    typedef struct packed {
        logic zeroCross;     // Bit 4
        logic ssiComm;       // Bit 3
        logic ssiJump;       // Bit 2
        logic limit;         // Bit 1
        logic overflow;      // Bit 0
    } chWarn_t;

endpackage

// ### rtl/blink_gen.sv
// Square-wave generator for the blinking warning indicator
`timescale 1ns/10ps
module blink_gen
    import fault_pkg::*;
#(
    parameter int HALF_CYC = BLINK_HALF_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clkEn,
    input  wire logic enable,
    output logic      blink
);

    // A zero-length half period cannot toggle sensibly
    if (HALF_CYC < 1) begin : gBadHalf
        $error("blink_gen: HALF_CYC must be at least 1");
    end

    localparam int CW = (HALF_CYC < 2) ? 1 : $clog2(HALF_CYC);

    logic [CW-1:0] count_r;   // Cycles spent in the current half
    logic          blink_r;   // Indicator phase
    wire           halfDone = (count_r == CW'(HALF_CYC - 1));

    // Restart from dark whenever blinking stops so each burst starts alike
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
            blink_r <= 1'b0;
        end else if (clkEn) begin
            if (!enable) begin
                count_r <= '0;
                blink_r <= 1'b0;
            end else if (halfDone) begin
                count_r <= '0;
                blink_r <= ~blink_r;
            end else begin
                count_r <= count_r + 1'b1;
            end
        end
    end

    assign blink = blink_r;

endmodule

// ### rtl/channel_warnings.sv
// Warning flags of one counter channel
`timescale 1ns/10ps
module channel_warnings
    import fault_pkg::*;
(
    input  wire logic    clk,
    input  wire logic    rst_n,
    input  wire logic    clkEn,
    input  wire chEvt_t  evt,
    output chWarn_t      warn
);

    chWarn_t warn_r;    // Flag state
    chWarn_t warn_nxt;  // Next flag state

    // Clearing conditions shared by overflow and zero-crossing
    wire counterReset = evt.counterClear | evt.runInstr;

    // Each set term except the jump flag's is ORed last so an event in a clear cycle is kept
    always_comb begin
        warn_nxt = warn_r;
        warn_nxt.overflow  = (warn_r.overflow & ~counterReset) | evt.overflow;
        warn_nxt.limit     = (warn_r.limit & ~evt.limitWrap) | evt.limitHit;
        // Each reading decides the flag afresh
        if (evt.ssiSample) begin
            warn_nxt.ssiJump = evt.ssiJumpBad;
        end
        // Link faults stay until the start instruction is run again
        warn_nxt.ssiComm   = (warn_r.ssiComm & ~evt.runInstr) | evt.ssiCommFault;
        warn_nxt.zeroCross = (warn_r.zeroCross & ~counterReset) | evt.zeroCross;
    end

    // Reset stands for a module restart and clears everything
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            warn_r <= '0;
        end else if (clkEn) begin
            warn_r <= warn_nxt;
        end
    end

    assign warn = warn_r;

endmodule

// ### verification/plc_host_model.sv
// Host controller model that re-downloads settings after a settings loss
`timescale 1ns/10ps
module plc_host_model
    import fault_pkg::*;
#(
    parameter int LOAD_DELAY = 5  // Host reaction time in cycles
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        autoLoad,       // Host may re-download
    input  wire logic [15:0] errorCode,      // Code read from the module
    output logic             configDownload  // One-cycle download done
);
    logic [7:0] waitCnt_r;  // Reaction delay counter
    logic       waitDone;   // Delay has run out

    assign waitDone = (waitCnt_r == 8'(LOAD_DELAY));

    // Pulse a download once the loss code has stood LOAD_DELAY cycles;
    // the counter restarts so a slow module is not hit twice at once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waitCnt_r      <= 8'h00;
            configDownload <= 1'b0;
        end else if (autoLoad && errorCode === CODE_SETTINGS_LOST) begin
            configDownload <= waitDone;
            waitCnt_r      <= waitDone ? 8'h00 : waitCnt_r + 8'h01;
        end else begin
            configDownload <= 1'b0;
            waitCnt_r      <= 8'h00;
        end
    end
endmodule

// ### verification/counter_fault_reporting_tb_top.sv
// Self-checking bench of the counter fault reporter
`timescale 1ns/10ps
module counter_fault_reporting_tb_top import fault_pkg::*; ;
    localparam int HALF  = 4;     // Short blink half period
    localparam int LIMIT = 3000;  // Cycle ceiling of the run

    logic              clk, rst_n, clkEn, autoLoad;  // Clock, reset, controls
    logic              countLossDetect, settingsLossDetect, placementMismatch;
    logic              configDownload;               // From host model
    chEvt_t  [1:0]     chEvt;                        // Channel events
    logic    [15:0]    errorCode;                    // Reported code
    logic              majorError, warningActive, errorLed;
    chWarn_t [1:0]     chWarn;                       // Warning flags
    int                numErrors, checkCount, cycles;

    counter_fault_reporting #(.NCH(2), .BLINK_HALF(HALF)) uut (
        .clk(clk), .rst_n(rst_n), .clkEn(clkEn),
        .countLossDetect(countLossDetect), .settingsLossDetect(settingsLossDetect),
        .configDownload(configDownload), .placementMismatch(placementMismatch),
        .chEvt(chEvt), .errorCode(errorCode), .majorError(majorError),
        .warningActive(warningActive), .errorLed(errorLed), .chWarn(chWarn)
    );

    plc_host_model #(.LOAD_DELAY(5)) host (
        .clk(clk), .rst_n(rst_n), .autoLoad(autoLoad),
        .errorCode(errorCode), .configDownload(configDownload)
    );

    // Compare one value, counting every check
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checkCount++;
        if (got !== exp) begin
            numErrors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Let n edges pass, then step off the edge so outputs are settled
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Restart the module, which stands for a power cycle
    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        tick(2);
    endtask

    // One-cycle event pulse on a channel, then room for the answer
    task automatic send(input int c, input logic [8:0] v);
        @(posedge clk);
        chEvt[c] <= chEvt_t'(v);
        @(posedge clk);
        chEvt[c] <= chEvt_t'(9'h000);
        tick(3);
    endtask

    // Count loss is steady, survives counter events, leaves only on restart
    task automatic test_count_loss;
        @(posedge clk);
        countLossDetect <= 1'b1;
        @(posedge clk);
        countLossDetect <= 1'b0;
        tick(3);
        chk("code", CODE_COUNT_LOST, errorCode);
        send(0, 9'h003);
        chk("code", CODE_COUNT_LOST, errorCode);
        chk("led", 16'h0001, 16'(errorLed));
        do_reset;
        chk("code", CODE_NONE, errorCode);
        $display("count loss test done");
    endtask

    // Settings loss sticks until the host downloads the setup again
    task automatic test_settings;
        @(posedge clk);
        settingsLossDetect <= 1'b1;
        @(posedge clk);
        settingsLossDetect <= 1'b0;
        tick(10);
        chk("code", CODE_SETTINGS_LOST, errorCode);
        chk("major", 16'h0001, 16'(majorError));
        @(posedge clk);
        autoLoad <= 1'b1;
        for (int i = 0; i < 20 && errorCode !== CODE_NONE; i++) tick(1);
        chk("code", CODE_NONE, errorCode);
        @(posedge clk);
        autoLoad <= 1'b0;
        $display("settings loss test done");
    endtask

    // Placement mismatch follows its input level
    task automatic test_placement;
        @(posedge clk);
        placementMismatch <= 1'b1;
        tick(4);
        chk("code", CODE_PLACEMENT, errorCode);
        chk("led", 16'h0001, 16'(errorLed));
        @(posedge clk);
        placementMismatch <= 1'b0;
        tick(4);
        chk("code", CODE_NONE, errorCode);
        chk("major", 16'h0000, 16'(majorError));
        $display("placement test done");
    endtask

    // Every warning kind on both channels, set then cleared by its own event
    task automatic test_warnings;
        logic [8:0] setV [7] = '{9'h100, 9'h080, 9'h030, 9'h008, 9'h004, 9'h100, 9'h004};
        logic [8:0] clrV [7] = '{9'h002, 9'h040, 9'h020, 9'h001, 9'h001, 9'h001, 9'h002};
        int         kind [7] = '{0, 1, 2, 3, 4, 0, 4};
        for (int c = 0; c < 2; c++) begin
            for (int r = 0; r < 7; r++) begin
                send(c, setV[r]);
                chk("code", CODE_WARN_BASE + 16'(2 * kind[r] + c), errorCode);
                chk("warn", 16'(10'h001 << (5 * c + kind[r])), 16'(chWarn));
                chk("major", 16'h0000, 16'(majorError));
                send(c, clrV[r]);
                chk("code", CODE_NONE, errorCode);
                chk("warn", 16'h0000, 16'(chWarn));
            end
            // Event and clear in one cycle: the event must win
            send(c, 9'h102);
            chk("setwins", 16'(10'h001 << (5 * c)), 16'(chWarn));
            send(c, 9'h002);
            chk("warn", 16'h0000, 16'(chWarn));
        end
        $display("warning table test done");
    endtask

    // Blink pattern, priority order, steady major, restart and clock enable
    task automatic test_blink;
        int   lit, tog;
        logic prev;
        send(1, 9'h100);
        send(0, 9'h080);
        chk("code", CODE_WARN_BASE + 16'h0001, errorCode);
        lit = 0;
        tog = 0;
        prev = errorLed;
        repeat (4 * HALF) begin
            tick(1);
            lit += int'(errorLed === 1'b1);
            tog += int'(errorLed !== prev);
            prev = errorLed;
        end
        chk("lit", 16'(2 * HALF), 16'(lit));
        chk("toggles", 16'h0004, 16'(tog));
        chk("warnact", 16'h0001, 16'(warningActive));
        @(posedge clk);
        placementMismatch <= 1'b1;
        tick(3);
        lit = 0;
        repeat (2 * HALF) begin
            tick(1);
            lit += int'(errorLed === 1'b1);
        end
        chk("steady", 16'(2 * HALF), 16'(lit));
        chk("code", CODE_PLACEMENT, errorCode);
        @(posedge clk);
        placementMismatch <= 1'b0;
        do_reset;
        chk("warn", 16'h0000, 16'(chWarn));
        @(posedge clk);
        clkEn <= 1'b0;
        send(0, 9'h100);
        @(posedge clk);
        clkEn <= 1'b1;
        tick(3);
        chk("code", CODE_NONE, errorCode);
        $display("blink and priority test done");
    endtask

    // Print counts and verdict, then end the run
    task automatic final_report;
        $display("checks %0d mismatches %0d", checkCount, numErrors);
        if (numErrors == 0 && checkCount > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            numErrors++;
            final_report;
        end
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        clkEn = 1'b1;
        autoLoad = 1'b0;
        countLossDetect = 1'b0;
        settingsLossDetect = 1'b0;
        placementMismatch = 1'b0;
        chEvt = '0;
        numErrors = 0;
        checkCount = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        tick(2);
        chk("code", CODE_NONE, errorCode);
        chk("led", 16'h0000, 16'(errorLed));
        test_count_loss;
        test_settings;
        test_placement;
        test_warnings;
        test_blink;
        final_report;
    end
endmodule
